// >>> src/ebc_break_ctrl.sv
// break and power-down control of the emulated 4-bit core
// assumes the core reports each fetch and each execute as one-cycle strobes
// and holds execution while halt is high
// fetch_run marks a fetch that continues a consecutive-description run,
// so the first fetch with fetch_run low is where such a run ends
// skip-class instructions report exec_skip_taken with their execute strobe
// slots with their pass enable set count executions, others match fetches
// the host reloads pass counts with bp_arm, which loads in any state, running included
// trigger lines may change at any time; two flops sit before edge detect
// trace pulses leave whatever the break enables say
// clk_en low freezes every flop, the synchroniser included
// halt, power_down and break_cause come straight from the state record
// cause codes: none, hardware or pass count, forced, trigger
// a forced break wins over every other source in the same cycle
// a deferred hit is dropped when a forced or trigger break stops the run
// only a hit inside a run is buffered, in defer; other strobes are judged in the cycle they stand
`timescale 1ns/1ps
`include "ebc_cfg.svh"
module ebc_break_ctrl #(
    parameter int ADDR_W = `EBC_ADDR_W,
    parameter int BP_NUM = `EBC_BP_NUM,
    parameter int PASS_W = `EBC_PASS_W,
    parameter int TRIG_N = `EBC_TRIG_NUM
) (
    // clock, reset and enable
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     clk_en,
    // core fetch side
    input  wire logic                     fetch_valid,
    input  wire logic [ADDR_W-1:0]        fetch_addr,
    input  wire logic                     fetch_run,
    // core execute side
    input  wire logic                     exec_valid,
    input  wire logic [ADDR_W-1:0]        exec_addr,
    input  wire ebc_pkg::ebc_class_t      exec_class,
    input  wire logic                     exec_skip_taken,
    // breakpoint slots from the host
    input  wire logic [BP_NUM-1:0]        bp_enable,
    input  wire logic [BP_NUM*ADDR_W-1:0] bp_addr,
    input  wire logic [BP_NUM-1:0]        bp_pass_en,
    input  wire logic [BP_NUM*PASS_W-1:0] bp_pass_load,
    input  wire logic                     bp_arm,
    // forced break and trigger lines
    input  wire logic                     force_break,
    input  wire logic [TRIG_N-1:0]        trig_in,
    input  wire logic [TRIG_N-1:0]        trig_brk_en,
    input  wire logic [TRIG_N-1:0]        trig_edge_fall,
    // host restart and wake
    input  wire logic                     restart,
    input  wire logic                     wake,
    // status back to the host
    output logic                          halt,
    output logic                          power_down,
    output logic [1:0]                    break_cause,
    output logic [TRIG_N-1:0]             trace_trig
);
    import ebc_pkg::*;

    ebc_state_rec_t s_q;
    ebc_state_rec_t s_d;
    logic [BP_NUM-1:0] hit_f;
    logic [BP_NUM-1:0] hit_e;
    logic [TRIG_N-1:0] edge_ev;
    logic [TRIG_N-1:0] rise_ev;
    logic [TRIG_N-1:0] fall_ev;
    logic              trig_brk;
    logic              pof_exec;
    logic              running;

    // pass count held for one slot
    function automatic logic [PASS_W-1:0] slot_cnt(input int i);
        slot_cnt = s_q.pass[i*PASS_W +: PASS_W];
    endfunction : slot_cnt

    // address match against one breakpoint slot
    function automatic logic bp_match(input logic [ADDR_W-1:0] a,
                                      input int i);
        bp_match = bp_enable[i] && (a == bp_addr[i*ADDR_W +: ADDR_W]);
    endfunction : bp_match

    // per-slot match on fetch (plain) and on real execution (pass count)
    genvar g;
    generate
        for (g = 0; g < BP_NUM; g++) begin : g_bp
            assign hit_f[g] = fetch_valid && !bp_pass_en[g] &&
                              bp_match(fetch_addr, g);
            assign hit_e[g] = exec_valid && !s_q.skip_next &&
                              bp_pass_en[g] &&
                              bp_match(exec_addr, g);
        end
    endgenerate

    // edge detect on the second synchroniser flop only
    generate
        for (g = 0; g < TRIG_N; g++) begin : g_trig
            // rising: now high, one cycle ago low
            assign rise_ev[g] = s_q.sync2[g] && !s_q.prev[g];
            // falling: now low, one cycle ago high
            assign fall_ev[g] = !s_q.sync2[g] && s_q.prev[g];
            // per-line polarity picks the qualifying edge
            assign edge_ev[g] = (trig_edge_fall[g] == `EBC_EDGE_RISE) ?
                                rise_ev[g] : fall_ev[g];
        end
    endgenerate

    // break sources and run state
    assign running  = (s_q.state == EBC_RUN);
    assign trig_brk = |(edge_ev & trig_brk_en);
    // only the power-off class sleeps; the enable class is ignored
    assign pof_exec = exec_valid && (exec_class == EBC_CLS_POF);

    // next-state logic
    always_comb begin
        // locals, given values before anything reads them
        logic hw_brk;
        logic pc_brk;
        logic [PASS_W-1:0] cnt;
        hw_brk = 1'b0;
        pc_brk = 1'b0;
        cnt    = '0;
        s_d = s_q;
        s_d.sync1 = trig_in;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        // pass counters count only executed instructions
        for (int i = 0; i < BP_NUM; i++) begin
            cnt = slot_cnt(i);
            if (bp_arm) begin
                s_d.pass[i*PASS_W +: PASS_W] =
                    bp_pass_load[i*PASS_W +: PASS_W];
            end else if (hit_e[i] && running) begin
                if (cnt <= `EBC_PASS_ONE) begin
                    pc_brk = 1'b1;
                end else begin
                    s_d.pass[i*PASS_W +: PASS_W] = cnt - `EBC_PASS_ONE;
                end
            end
        end

        // skip tracking: successor of a taken skip is not executed
        if (exec_valid) begin
            s_d.skip_next = (exec_class == EBC_CLS_SKIP) &&
                            exec_skip_taken && !s_q.skip_next;
        end

        // plain slots: a skipped fetch never breaks on its own match; a deferred hit still stops there
        hw_brk = (|hit_f) && !s_q.skip_next;
        case (s_q.state)
            EBC_RUN: begin
                if (force_break || trig_brk) begin
                    // forced and trigger breaks stop at once, run or not
                    s_d.state = EBC_HALT;
                    s_d.cause = force_break ? `EBC_CAUSE_FORCE :
                                              `EBC_CAUSE_TRIG;
                    // drop a deferred hit; host resumes after the run
                    s_d.defer = 1'b0;
                end else if (fetch_valid && fetch_run &&
                             (hw_brk || s_q.defer)) begin
                    // inside a run a hit only waits for the run to end
                    s_d.defer = 1'b1;
                end else if ((hw_brk || s_q.defer) && fetch_valid) begin
                    // first fetch past the run: stop before it executes
                    s_d.state = EBC_HALT;
                    s_d.cause = `EBC_CAUSE_HW;
                    s_d.defer = 1'b0;
                end else if (pc_brk) begin
                    // pass count ran out on a real execution
                    s_d.state = EBC_HALT;
                    s_d.cause = `EBC_CAUSE_HW;
                end else if (pof_exec) begin
                    // power-off executed: sleep until wake
                    s_d.state = EBC_PDN;
                end
            end
            EBC_HALT: begin
                // cause clears on restart; skip memory starts fresh
                if (restart) begin
                    s_d.state = EBC_RUN;
                    s_d.cause = `EBC_CAUSE_NONE;
                    s_d.skip_next = 1'b0;
                end
            end
            EBC_PDN: begin
                // only wake leaves power-down
                if (wake) begin
                    s_d.state = EBC_RUN;
                end
            end
            default: s_d.state = EBC_RUN;
        endcase
    end

    // state register with clock enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // run, with counters and flops clear
            s_q <= '{state: EBC_RUN, default: '0};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // status straight from the state record
    assign halt        = (s_q.state == EBC_HALT);
    assign power_down  = (s_q.state == EBC_PDN);
    assign break_cause = s_q.cause;
    // trace pulses go out whatever the break enables
    assign trace_trig  = edge_ev;
endmodule : ebc_break_ctrl

// >>> src/ebc_cfg.svh
// emulator break control constants
// assumes inclusion by the package and the top module only
`ifndef EBC_CFG_SVH
`define EBC_CFG_SVH
`define EBC_ADDR_W      12
`define EBC_BP_NUM      4
`define EBC_PASS_W      8
`define EBC_TRIG_NUM    2
`define EBC_EDGE_RISE   1'b0
`define EBC_PASS_ONE    8'h01
`define EBC_CAUSE_NONE  2'h0
`define EBC_CAUSE_HW    2'h1
`define EBC_CAUSE_FORCE 2'h2
`define EBC_CAUSE_TRIG  2'h3
`endif

// >>> src/ebc_pkg.sv
// emulator break control types
// assumes the constants header is on the include path
`include "ebc_cfg.svh"
package ebc_pkg;
    // instruction classes decoded by the core
    typedef enum logic [3:0] {
        EBC_CLS_OTHER = 4'h0,
        EBC_CLS_SKIP  = 4'h1,
        EBC_CLS_POF   = 4'h2,
        EBC_CLS_POWER_OFF_ENABLE_INSTR  = 4'h3
    } ebc_class_t;

    // run state, one-hot
    typedef enum logic [2:0] {
        EBC_RUN  = 3'h1,
        EBC_HALT = 3'h2,
        EBC_PDN  = 3'h4
    } ebc_state_t;

    typedef struct packed {
        ebc_state_t                        state;
        logic                              defer;
        logic                              skip_next;
        logic [`EBC_TRIG_NUM-1:0]          sync1;
        logic [`EBC_TRIG_NUM-1:0]          sync2;
        logic [`EBC_TRIG_NUM-1:0]          prev;
        logic [`EBC_BP_NUM*`EBC_PASS_W-1:0] pass;
        logic [1:0]                        cause;
    } ebc_state_rec_t;
endpackage : ebc_pkg

// >>> tb/ebc_break_ctrl_tb.sv
// bench for the break control block with a core model beside it
// assumes the package, header and design are compiled first
`timescale 1ns/1ps
module ebc_break_ctrl_tb;
    import ebc_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, force_break = 1'b0, restart = 1'b0;
    logic wake = 1'b0, bp_arm = 1'b0, fetch_valid, fetch_run, exec_valid;
    logic exec_skip_taken, halt, power_down;
    logic [11:0] fetch_addr, exec_addr;
    logic [1:0] break_cause, trace_trig, trig_in = 2'h0, edge_fall = 2'h0;
    logic [3:0] bp_enable = 4'h3;
    logic [47:0] bp_addr = 48'h000000030010;
    ebc_class_t exec_class;
    int failures = 0, comparisons = 0, ntrace = 0;
    wire [3:0] sv = {halt, power_down, break_cause};
    initial forever #12.5 clk = ~clk;
    always @(negedge clk) if (trace_trig[0] === 1'b1) ntrace++;
    ebc_core_model i_ebc_core_model (.*);
    ebc_break_ctrl i_ebc_break_ctrl (.clk_en(1'b1), .bp_pass_en(4'h2),
        .bp_pass_load(32'h0000_0200), .trig_brk_en(2'h1),
        .trig_edge_fall(edge_fall), .*);
    task automatic chk(input logic [3:0] g, input logic [3:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic go(input logic [11:0] a, input logic r, input ebc_class_t c);
        i_ebc_core_model.step(a, r, c, c == EBC_CLS_SKIP);
    endtask : go
    task automatic resume();
        @(posedge clk) restart <= 1'b1;
        @(posedge clk) restart <= 1'b0;
    endtask : resume
    task automatic t_power();
        go(12'h100, 1'b0, EBC_CLS_POWER_OFF_ENABLE_INSTR);
        #1 chk(sv, 4'h0);
        go(12'h101, 1'b0, EBC_CLS_POF);
        #1 chk(sv, 4'h4);
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        #1 chk(sv, 4'h0);
        $display("power-down test done");
    endtask : t_power
    task automatic t_run();
        go(12'h010, 1'b1, EBC_CLS_OTHER);
        #1 chk(sv, 4'h0);
        go(12'h011, 1'b1, EBC_CLS_OTHER);
        #1 chk(sv, 4'h0);
        go(12'h012, 1'b0, EBC_CLS_OTHER);
        #1 chk(sv, 4'h9);
        resume();
        go(12'h010, 1'b1, EBC_CLS_OTHER);
        @(posedge clk) force_break <= 1'b1;
        go(12'h011, 1'b1, EBC_CLS_OTHER);
        force_break <= 1'b0;
        #1 chk(sv, 4'hA);
        resume();
        go(12'h012, 1'b0, EBC_CLS_OTHER);
        #1 chk(sv, 4'h0);
        $display("run and forced break test done");
    endtask : t_run
    task automatic t_skip();
        go(12'h020, 1'b0, EBC_CLS_SKIP);
        go(12'h010, 1'b0, EBC_CLS_OTHER);
        #1 chk(sv, 4'h0);
        go(12'h020, 1'b0, EBC_CLS_SKIP);
        go(12'h030, 1'b0, EBC_CLS_OTHER);
        go(12'h030, 1'b0, EBC_CLS_OTHER);
        #1 chk(sv, 4'h0);
        go(12'h030, 1'b0, EBC_CLS_OTHER);
        #1 chk(sv, 4'h9);
        resume();
        $display("skip and pass count test done");
    endtask : t_skip
    task automatic t_trig(input logic f);
        int n;
        @(posedge clk) edge_fall[0] <= f;
        n = ntrace;
        @(posedge clk) trig_in[0] <= ~trig_in[0];
        repeat (6) @(posedge clk);
        #1 chk(sv, 4'hB);
        chk(4'(ntrace - n), 4'h1);
        resume();
        $display("trigger edge test done");
    endtask : t_trig
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk) bp_arm <= 1'b1;
        @(posedge clk) bp_arm <= 1'b0;
        t_power();
        t_run();
        t_skip();
        t_trig(1'b0);
        t_trig(1'b1);
        wrap_up();
    end
endmodule : ebc_break_ctrl_tb

// >>> tb/ebc_core_model.sv
// emulated core: one fetch strobe, then its execute strobe
// assumes the bench calls step once per instruction
`timescale 1ns/1ps
module ebc_core_model (
    input  wire logic           clk,
    output logic                fetch_valid, fetch_run,
    output logic                exec_valid, exec_skip_taken,
    output logic [11:0]         fetch_addr, exec_addr,
    output ebc_pkg::ebc_class_t exec_class
);
    initial {fetch_valid, fetch_run, exec_valid, exec_skip_taken} = 4'h0;
    initial {fetch_addr, exec_addr} = 24'h0;
    initial exec_class = ebc_pkg::EBC_CLS_OTHER;
    // released address lines show the inverse, not a stale value
    task automatic step(input logic [11:0] a, input logic r,
                        input ebc_pkg::ebc_class_t c, input logic s);
        @(posedge clk) {fetch_valid, fetch_run, fetch_addr} <= {1'b1, r, a};
        @(posedge clk) {fetch_valid, fetch_addr} <= {1'b0, ~a};
        {exec_valid, exec_addr, exec_skip_taken} <= {1'b1, a, s};
        exec_class <= c;
        @(posedge clk) {exec_valid, exec_addr} <= {1'b0, ~a};
    endtask : step
endmodule : ebc_core_model

// >>> tb/ebc_props.sv
// assertions on the break control ports
// assumes binding onto the break control top module
`timescale 1ns/1ps
module ebc_props
    import ebc_pkg::*;
#(parameter int TRIG_N = 2) (
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              clk_en,
    input wire logic              halt,
    input wire logic              power_down,
    input wire logic              fetch_valid,
    input wire logic              fetch_run,
    input wire logic              exec_valid,
    input wire logic              force_break,
    input wire logic              restart,
    input wire logic              wake,
    input wire ebc_class_t        exec_class,
    input wire logic [1:0]        break_cause,
    input wire logic [TRIG_N-1:0] trace_trig,
    input wire logic [TRIG_N-1:0] trig_brk_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // running and accepting breaks
    wire idle = clk_en && !halt && !power_down;
    a_pof_sleep: assert property (
        idle && exec_valid && exec_class == EBC_CLS_POF && !force_break
        && !fetch_valid && !(|(trace_trig & trig_brk_en)) |=> power_down)
        else $error("no power-down");
    a_sleep_cause: assert property (
        $rose(power_down) |-> $past(exec_valid && exec_class == EBC_CLS_POF))
        else $error("power-down without power-off");
    a_force_halt: assert property (
        idle && force_break |=> halt) else $error("forced break lost");
    a_run_quiet: assert property (
        idle && fetch_valid && fetch_run && !exec_valid && !force_break
        && !(|trace_trig) |=> !halt) else $error("halt inside run");
    a_trig_halt: assert property (
        idle && |(trace_trig & trig_brk_en) |=> halt)
        else $error("trigger break lost");
    a_trace_pulse: assert property (
        clk_en && trace_trig[0] |=> !trace_trig[0])
        else $error("trace pulse too long");
    a_halt_holds: assert property (
        halt && !restart |=> halt && $stable(break_cause))
        else $error("halt dropped");
    a_wake_leaves: assert property (
        clk_en && power_down && wake |=> !power_down)
        else $error("wake ignored");
    a_restart_ends: assert property (
        clk_en && halt && restart && !force_break |=> !halt)
        else $error("restart ignored");
    c_trig: cover property (halt && break_cause == 2'h3);
    c_hw: cover property (halt && break_cause == 2'h1);
    c_pd: cover property (power_down);
    c_force: cover property (halt && break_cause == 2'h2);
endmodule : ebc_props
bind ebc_break_ctrl ebc_props #(.TRIG_N(TRIG_N)) i_props (.*);
